/* File: rtcc_control.sv */
// What this block does
// - Address 15 shows time format setup if select is 0, timer setup if 1.
// - Timekeeping and interval timing run regardless of the address-15 selection.
// - Time format setup: leap count bits 3:2, AM/PM bit 1, format bit 0.
// - Two-bit leap counter increments at New Year; zero means leap year.
// - Day count wraps at 28, 29, 30 or 31 by month and leap count.
// - AM/PM toggles at 11:59 to 12:00 in 12-hour mode; zero in 24-hour.
// - Format 0 counts hours 1 to 12; format 1 counts 0 to 23.
// - Interval code selects none, 0.1, 0.5, 1, 5, 10, 30 or 60 s.
// - Timer setup bit 3 picks one-shot or periodic timeouts.
// - Zero code clears interrupt, forces timer halt; new code waits for halt clear.
// - Timeouts within 1 ms; periodic timeouts stay locked to the first.
// - Address 0 writes load test, clock halt, select and timer halt.
// - Address 0 reads give time changed flag bit 3, zeros, timeout flag bit 0.
// - Test bit 1 enters test mode; 0 returns to normal.
// - Test mode with a zero interval code puts the buffered oscillator on the interrupt pin.
// - Clock halt stops timekeeping and clears tenths; clearing it resumes.
// - Timer halt stops and resets the timer; release gives a full interval.
// - One-shot timer stops after timeout; periodic keeps counting.
// - Update pulse sets time changed flag; only an address-0 read clears it.
// - Update pulse every 100 ms, all counters changing together.
// - Timeout sets timeout flag and drives interrupt low; address-0 read clears.
// - Clearing at read strobe trailing edge; flags frozen during the read.
// - Timeout during address-0 read is held, interrupt asserted after the read.
// - Update pulse during an address-0 read does not set the flag.
`timescale 1ns/100ps
`include "rtcc_consts.svh"
module rtcc_control #(
    parameter int TICK_CYC     = `RTCC_TICK_CYC,
    parameter int OSC_HALF_CYC = `RTCC_OSC_HALF_CYC
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [3:0] addr,
    input  wire logic [3:0] db_in,
    output logic      [3:0] db_out,
    output logic            db_oe,
    output logic            int_out,
    output logic            int_oe,
    output logic            tick
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic       cs_m, rd_m, wr_m;
    logic [3:0] a_m, a_s, d_m, d_s;
    logic       cs_s, rd_s, wr_s;
    always_ff @(posedge mclk) begin
        cs_m <= cs_n;
        rd_m <= rd_n;
        wr_m <= wr_n;
        a_m  <= addr;
        d_m  <= db_in;
        cs_s <= cs_m;
        rd_s <= rd_m;
        wr_s <= wr_m;
        a_s  <= a_m;
        d_s  <= d_m;
    end

    logic rd_act, wr_act, rd_act_q, wr_act_q;
    logic ctrl_rd, ctrl_rd_end, wr_pulse;
    assign rd_act = !cs_s && !rd_s;
    assign wr_act = !cs_s && !wr_s;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
        end
    end
    assign ctrl_rd     = rd_act && a_s == `RTCC_ADDR_CTRL;
    assign wr_pulse    = wr_act && !wr_act_q;
    // Address held for the read; ends when the strobe rises
    logic ctrl_rd_q;
    always_ff @(posedge mclk) begin
        if (!reset_n)
            ctrl_rd_q <= 1'b0;
        else if (rd_act && !rd_act_q)
            ctrl_rd_q <= a_s == `RTCC_ADDR_CTRL;
        else if (!rd_act)
            ctrl_rd_q <= 1'b0;
    end
    assign ctrl_rd_end = ctrl_rd_q && !rd_act;

    ////////////////////////////////////////////////////////////////////////////////
    // Control latches and setup registers
    logic       test_mode, clk_halt, sel_timer, tmr_halt, tmr_kick;
    logic [1:0] leap_count;
    logic       pm, fmt24;
    logic [2:0] code;
    logic       repeat_mode;
    logic       new_year, noon_edge;
    logic       wr_ctrl, wr_setup;
    assign wr_ctrl  = wr_pulse && a_s == `RTCC_ADDR_CTRL;
    assign wr_setup = wr_pulse && a_s == `RTCC_ADDR_SETUP;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            test_mode <= 1'b0;
            clk_halt  <= 1'b1;
            sel_timer <= 1'b0;
            tmr_halt  <= 1'b1;
        end else begin
            if (wr_ctrl) begin
                test_mode <= d_s[`RTCC_BIT_TEST];
                clk_halt  <= d_s[`RTCC_BIT_CLK_HALT];
                sel_timer <= d_s[`RTCC_BIT_SEL];
                tmr_halt  <= d_s[`RTCC_BIT_TMR_HALT];
            end
            if (code == `RTCC_CODE_OFF)
                tmr_halt <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            code        <= `RTCC_CODE_OFF;
            repeat_mode <= 1'b0;
        end else if (wr_setup && sel_timer) begin
            code        <= d_s[2:0];
            repeat_mode <= d_s[3];
        end
    end

    // One-shot restarts on each write of 0 to the halt bit, even if it already reads 0
    always_ff @(posedge mclk) begin
        if (!reset_n)
            tmr_kick <= 1'b0;
        else
            tmr_kick <= wr_ctrl && !d_s[`RTCC_BIT_TMR_HALT] && !repeat_mode;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            leap_count <= `RTCC_LEAP_RST;
            pm         <= 1'b0;
            fmt24      <= 1'b0;
        end else if (wr_setup && !sel_timer) begin
            leap_count <= d_s[3:2];
            fmt24      <= d_s[0];
            pm         <= d_s[0] ? 1'b0 : d_s[1];
        end else begin
            if (new_year)
                leap_count <= leap_count + 2'h1;
            if (fmt24)
                pm <= 1'b0;
            else if (noon_edge)
                pm <= !pm;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Update pulse and a minimal calendar (BCD) driving the setup bits
    logic [26:0] tick_cyc;
    logic        tick_now;
    logic [3:0]  tenths;
    logic [6:0]  sec, min;
    logic [5:0]  hour, day;
    logic [4:0]  month;
    logic        sec_roll, min_roll, day_roll;
    logic [5:0]  hour_last, day_last;
    assign tick_now = !clk_halt && tick_cyc == 27'(TICK_CYC - 1);
    always_ff @(posedge mclk) begin
        if (!reset_n || clk_halt)
            tick_cyc <= 27'h0;
        else
            tick_cyc <= tick_now ? 27'h0 : tick_cyc + 27'h1;
    end
    always_ff @(posedge mclk) begin
        if (!reset_n)
            tick <= 1'b0;
        else
            tick <= tick_now;
    end

    function automatic logic [6:0] bcd_inc(input logic [6:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[6:4] + 3'h1, 4'h0} : {v[6:4], v[3:0] + 4'h1};
    endfunction

    always_comb begin
        unique case (month)
            5'h04, 5'h06, 5'h09, 5'h11: day_last = 6'h30;
            `RTCC_MONTH_FEB:            day_last = leap_count == 2'h0 ? 6'h29 : 6'h28;
            default:                    day_last = `RTCC_DAY_LAST_DAY_DEC;
        endcase
        hour_last = fmt24 ? 6'h23 : 6'h12;
    end

    assign sec_roll  = tick_now && tenths == `RTCC_TENTHS_9 && sec == `RTCC_SEC_59;
    assign min_roll  = sec_roll && min == `RTCC_MIN_59;
    assign noon_edge = min_roll && hour == `RTCC_HOUR_11;
    assign day_roll  = min_roll && (fmt24 ? hour == 6'h23 : (hour == `RTCC_HOUR_11 && pm));
    assign new_year  = day_roll && day == day_last && month == `RTCC_MONTH_DEC;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tenths <= 4'h0;
            sec    <= 7'h0;
            min    <= 7'h0;
            hour   <= 6'h12;
            day    <= 6'h01;
            month  <= 5'h01;
        end else if (clk_halt) begin
            tenths <= 4'h0;
        end else if (tick_now) begin
            tenths <= tenths == `RTCC_TENTHS_9 ? 4'h0 : tenths + 4'h1;
            if (tenths == `RTCC_TENTHS_9)
                sec <= sec == `RTCC_SEC_59 ? 7'h0 : bcd_inc(sec);
            if (sec_roll)
                min <= min == `RTCC_MIN_59 ? 7'h0 : bcd_inc(min);
            if (min_roll)
                hour <= hour == hour_last ? (fmt24 ? 6'h00 : 6'h01)
                                          : 6'(bcd_inc({1'b0, hour}));
            if (day_roll)
                day <= day == day_last ? 6'h01 : 6'(bcd_inc({1'b0, day}));
            if (day_roll && day == day_last)
                month <= month == `RTCC_MONTH_DEC ? 5'h01
                                                  : 5'(bcd_inc({2'b00, month}));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interval timer, flags and interrupt
    logic timeout, tcf, tof, tof_pend;
    rtcc_interval_timer #(.TICK_CYC(TICK_CYC)) u_timer (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .halt        (tmr_halt || tmr_kick),
        .repeat_mode (repeat_mode),
        .code        (code),
        .timeout     (timeout)
    );

    always_ff @(posedge mclk) begin
        if (!reset_n)
            tcf <= 1'b0;
        else if (tick_now && !ctrl_rd && !ctrl_rd_q)
            tcf <= 1'b1;
        else if (ctrl_rd_end)
            tcf <= 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tof      <= 1'b0;
            tof_pend <= 1'b0;
        end else if (ctrl_rd_q || ctrl_rd) begin
            if (timeout)
                tof_pend <= 1'b1;
            if (ctrl_rd_end)
                tof <= 1'b0;
        end else if (code == `RTCC_CODE_OFF) begin
            tof      <= 1'b0;
            tof_pend <= 1'b0;
        end else if (timeout || tof_pend) begin
            tof      <= 1'b1;
            tof_pend <= 1'b0;
        end
    end

    logic [26:0] osc_cnt;
    logic        osc;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            osc_cnt <= 27'h0;
            osc     <= 1'b0;
        end else if (osc_cnt == 27'(OSC_HALF_CYC - 1)) begin
            osc_cnt <= 27'h0;
            osc     <= !osc;
        end else begin
            osc_cnt <= osc_cnt + 27'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            int_out <= 1'b0;
            int_oe  <= 1'b0;
        end else if (test_mode && code == `RTCC_CODE_OFF) begin
            int_out <= osc;
            int_oe  <= 1'b1;
        end else begin
            int_out <= 1'b0;
            int_oe  <= tof;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            db_out <= 4'h0;
            db_oe  <= 1'b0;
        end else begin
            db_oe <= rd_act;
            if (a_s == `RTCC_ADDR_CTRL)
                db_out <= {tcf, 2'b00, tof};
            else if (a_s == `RTCC_ADDR_SETUP)
                db_out <= sel_timer ? {repeat_mode, code} : {leap_count, pm, fmt24};
            else
                db_out <= 4'h0;
        end
    end

    chk_read_freezes: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_rd_q && rd_act |=> $stable(tcf) || ctrl_rd_end)
        else $error("time changed flag moved during read");
    chk_zero_code_halt: assert property (@(posedge mclk) disable iff (!reset_n)
        code == `RTCC_CODE_OFF |=> tmr_halt)
        else $error("timer not halted with zero code");
    chk_24h_no_pm: assert property (@(posedge mclk) disable iff (!reset_n)
        fmt24 && !wr_setup |=> !pm)
        else $error("pm set in 24-hour mode");
    chk_read_clears: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_rd_end && !timeout && !tof_pend |=> !tof ##1 !int_oe || test_mode)
        else $error("read did not clear timeout");
    chk_halt_tenths: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_halt |=> tenths == 4'h0 && !tick_now)
        else $error("tenths not held in halt");
    chk_pend_waits: assert property (@(posedge mclk) disable iff (!reset_n)
        ctrl_rd_q && rd_act && !tof && !test_mode |=> !int_oe)
        else $error("interrupt asserted during control read");
endmodule

/* File: rtcc_consts.svh */
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH
`define RTCC_ADDR_CTRL        4'h0
`define RTCC_ADDR_SETUP       4'hf
`define RTCC_BIT_TEST         3
`define RTCC_BIT_CLK_HALT     2
`define RTCC_BIT_SEL          1
`define RTCC_BIT_TMR_HALT     0
`define RTCC_BIT_DCF          3
`define RTCC_BIT_TOF          0
`define RTCC_CLK_HZ           125000000
`define RTCC_TICK_MS          100
`define RTCC_TICK_CYC         ((`RTCC_CLK_HZ / 1000) * `RTCC_TICK_MS)
`define RTCC_OSC_HZ           32768
`define RTCC_OSC_HALF_CYC     (`RTCC_CLK_HZ / (2 * `RTCC_OSC_HZ))
`define RTCC_CODE_OFF         3'h0
`define RTCC_LEAP_RST         2'h0
`define RTCC_MONTH_DEC        5'h12
`define RTCC_MONTH_FEB        5'h02
`define RTCC_DAY_LAST_DAY_DEC 6'h31
`define RTCC_HOUR_11          6'h11
`define RTCC_MIN_59           7'h59
`define RTCC_SEC_59           7'h59
`define RTCC_TENTHS_9         4'h9
`endif

/* File: rtcc_pkg.sv */
package rtcc_pkg;
    typedef enum logic [1:0] {
        RTCC_IDLE  = 2'b00,
        RTCC_RUN   = 2'b01,
        RTCC_DONE  = 2'b10
    } rtcc_tmr_e;
    typedef logic [3:0] rtcc_nib_t;
endpackage

/* File: rtcc_interval_timer.sv */
`timescale 1ns/100ps
`include "rtcc_consts.svh"
module rtcc_interval_timer #(
    parameter int TICK_CYC = `RTCC_TICK_CYC
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       halt,
    input  wire logic       repeat_mode,
    input  wire logic [2:0] code,
    output logic            timeout
);
    ////////////////////////////////////////////////////////////////////////////////
    // Tenths of a second per interval code
    function automatic logic [9:0] tenths_of(input logic [2:0] c);
        unique case (c)
            3'h1:    tenths_of = 10'h001;
            3'h2:    tenths_of = 10'h005;
            3'h3:    tenths_of = 10'h00a;
            3'h4:    tenths_of = 10'h032;
            3'h5:    tenths_of = 10'h064;
            3'h6:    tenths_of = 10'h12c;
            3'h7:    tenths_of = 10'h258;
            default: tenths_of = 10'h000;
        endcase
    endfunction

    rtcc_pkg::rtcc_tmr_e state;
    logic [26:0]         cyc;
    logic [9:0]          tenths;
    logic                tenth_done;
    logic                last_tenth;

    assign tenth_done = (cyc == 27'(TICK_CYC - 1));
    assign last_tenth = (tenths == tenths_of(code) - 10'h001);

    // Free-running from the start, so repeats stay phase locked to the first
    always_ff @(posedge mclk) begin
        if (!reset_n || halt || state != rtcc_pkg::RTCC_RUN) begin
            cyc    <= 27'h0;
            tenths <= 10'h0;
        end else if (tenth_done) begin
            cyc    <= 27'h0;
            tenths <= last_tenth ? 10'h0 : tenths + 10'h001;
        end else begin
            cyc <= cyc + 27'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n || halt) begin
            state <= rtcc_pkg::RTCC_IDLE;
        end else begin
            unique case (state)
                rtcc_pkg::RTCC_IDLE: state <= rtcc_pkg::RTCC_RUN;
                rtcc_pkg::RTCC_RUN:
                    if (tenth_done && last_tenth && !repeat_mode)
                        state <= rtcc_pkg::RTCC_DONE;
                rtcc_pkg::RTCC_DONE: state <= rtcc_pkg::RTCC_DONE;
                default: state <= rtcc_pkg::RTCC_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n || halt)
            timeout <= 1'b0;
        else
            timeout <= state == rtcc_pkg::RTCC_RUN && tenth_done && last_tenth;
    end

    chk_oneshot_stops: assert property (@(posedge mclk) disable iff (!reset_n)
        timeout && !repeat_mode && !halt |=> ##1 !timeout [*3])
        else $error("one-shot timer fired twice");
    chk_halt_silences: assert property (@(posedge mclk) disable iff (!reset_n)
        halt |=> !timeout)
        else $error("timeout while halted");
endmodule

/* File: rtcc_cpu_model.sv */
`timescale 1ns/100ps
module rtcc_cpu_model (
    input  wire logic       mclk,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [3:0] addr,
    output logic      [3:0] db_in
);
    initial begin
        cs_n  = 1'b1;
        rd_n  = 1'b1;
        wr_n  = 1'b1;
        addr  = 4'h0;
        db_in = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobes stay low and high well past the synchroniser depth
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(negedge mclk);
        addr  = a;
        db_in = d;
        cs_n  = 1'b0;
        wr_n  = 1'b0;
        repeat (5) @(negedge mclk);
        cs_n  = 1'b1;
        wr_n  = 1'b1;
        // Released bus shows the inverse, not a stale copy
        db_in = ~d;
        repeat (4) @(negedge mclk);
        addr  = ~a;
    endtask

    task automatic rd(input logic [3:0] a, input int h);
        @(negedge mclk);
        addr = a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (h) @(negedge mclk);
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (6) @(negedge mclk);
        addr = ~a;
    endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic        mclk;
    logic        reset_n;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic [3:0]  addr;
    logic [3:0]  db_in;
    logic [3:0]  db_out;
    logic        db_oe;
    logic        int_out;
    logic        int_oe;
    logic        tick;
    wire         int_pin = int_oe ? int_out : 1'b1;
    int          fails = 0;
    int          comparisons = 0;
    int          tick_cnt = 0;
    logic [3:0]  exp_q[$];
    logic [3:0]  msk_q[$];
    logic        seen = 1'b0;
    logic [31:0] seed = 32'ha9d9;
    int          mult[8] = '{0, 1, 5, 10, 50, 100, 300, 600};
    int          i;
    int          k;
    int          n;
    time         t1;

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    rtcc_cpu_model cpu (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
                        .addr(addr), .db_in(db_in));

    rtcc_control #(.TICK_CYC(40), .OSC_HALF_CYC(5)) dut (
        .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
        .int_out(int_out), .int_oe(int_oe), .tick(tick));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic rd(input logic [3:0] a, input logic [3:0] e, input logic [3:0] m,
                      input int h);
        exp_q.push_back(e);
        msk_q.push_back(m);
        cpu.rd(a, h);
    endtask

    // Counts pin transitions over c cycles
    task automatic cnt(input int c, output int n);
        logic last;
        n = 0;
        last = int_pin;
        repeat (c) begin
            @(negedge mclk);
            if (int_pin !== last)
                n++;
            last = int_pin;
        end
    endtask

    task automatic tmo(input int ne);
        int w;
        w = 0;
        while (int_pin !== 1'b0 && w < ne + 40) begin
            @(negedge mclk);
            w++;
        end
        chk(w >= ne - 12 && w <= ne + 4, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read data watcher takes the oldest note on each read answer
    always @(negedge mclk) begin
        if (db_oe === 1'b1 && !seen) begin
            if (exp_q.size() == 0)
                chk(db_out, 4'hx);
            else
                chk(db_out & msk_q.pop_front(), exp_q.pop_front());
        end
        seen = (db_oe === 1'b1);
    end

    always @(posedge mclk)
        if (tick === 1'b1)
            tick_cnt++;

    initial begin
        #800000;
        fails++;
        close_out;
    end

    initial begin
        reset_n = 1'b0;
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        rd(4'h0, 4'h0, 4'hf, 5);
        cpu.wr(4'h0, 4'h5);
        for (i = 0; i < 4; i++) begin
            seed = xs(seed);
            cpu.wr(4'hf, {seed[1:0], 2'b00});
            rd(4'hf, {seed[1:0], 2'b00}, 4'hf, 5);
        end
        cpu.wr(4'hf, 4'h1);
        rd(4'hf, 4'h1, 4'hf, 5);
        cpu.wr(4'hf, 4'h3);
        rd(4'hf, 4'h1, 4'hf, 5);
        cpu.wr(4'hf, 4'h0);
        cpu.wr(4'h5, 4'h9);
        rd(4'h5, 4'h0, 4'hf, 5);
        cpu.wr(4'h0, 4'h7);
        cpu.wr(4'hf, 4'h9);
        rd(4'hf, 4'h9, 4'hf, 5);
        cpu.wr(4'h0, 4'h5);
        rd(4'hf, 4'h0, 4'hf, 5);
        // Update pulse rate and data changed flag
        cpu.wr(4'h0, 4'h3);
        @(posedge tick);
        t1 = $time;
        @(posedge tick);
        chk(($time - t1) / 8, 40);
        cpu.wr(4'h0, 4'h7);
        rd(4'h0, 4'h8, 4'hf, 5);
        rd(4'h0, 4'h0, 4'hf, 5);
        k = tick_cnt;
        repeat (100) @(negedge mclk);
        chk(tick_cnt - k, 0);
        cpu.wr(4'h0, 4'h3);
        @(posedge tick);
        rd(4'h0, 4'h8, 4'hf, 90);
        rd(4'h0, 4'h0, 4'hf, 5);
        // Oscillator on the interrupt pin
        cpu.wr(4'h0, 4'h7);
        cpu.wr(4'hf, 4'h0);
        cpu.wr(4'h0, 4'hf);
        cnt(100, n);
        chk(n >= 19 && n <= 21, 1);
        cpu.wr(4'h0, 4'h7);
        cnt(100, n);
        chk(n == 0 && int_pin === 1'b1, 1);
        // Every interval code, one-shot
        for (i = 1; i < 8; i++) begin
            cpu.wr(4'hf, i[3:0]);
            cpu.wr(4'h0, 4'h6);
            tmo(mult[i] * 40);
            rd(4'h0, 4'h1, 4'hf, 5);
            chk(int_pin, 1);
            if (i == 1) begin
                cnt(120, n);
                chk(n == 0 && int_pin === 1'b1, 1);
            end
        end
        // Periodic timeouts stay locked to the first
        cpu.wr(4'h0, 4'h7);
        cpu.wr(4'hf, 4'h9);
        cpu.wr(4'h0, 4'h6);
        tmo(40);
        t1 = $time;
        rd(4'h0, 4'h1, 4'hf, 5);
        tmo(26);
        chk(($time - t1) / 8, 40);
        rd(4'h0, 4'h1, 4'hf, 5);
        tmo(26);
        chk(($time - t1) / 8, 80);
        rd(4'h0, 4'h1, 4'hf, 5);
        rd(4'h0, 4'h0, 4'hf, 40);
        cnt(0, n);
        k = 0;
        while (int_pin !== 1'b0 && k < 8) begin
            @(negedge mclk);
            k++;
        end
        chk(int_pin, 0);
        rd(4'h0, 4'h1, 4'hf, 5);
        // Halt resets the timer, zero code forces halt
        cpu.wr(4'h0, 4'h7);
        cnt(150, n);
        chk(n == 0 && int_pin === 1'b1, 1);
        cpu.wr(4'h0, 4'h6);
        tmo(40);
        cpu.wr(4'hf, 4'h0);
        chk(int_pin, 1);
        cpu.wr(4'hf, 4'h1);
        cnt(120, n);
        chk(n == 0 && int_pin === 1'b1, 1);
        cpu.wr(4'h0, 4'h6);
        tmo(40);
        rd(4'h0, 4'h1, 4'hf, 5);
        repeat (10) @(negedge mclk);
        chk(exp_q.size(), 0);
        close_out;
    end
endmodule
